// ### shared/cpp_pkg.sv
// constants, types and helpers shared by the configurable pin port
package cpp_pkg;
  localparam int NPINS = 19;
  localparam int PWM_MAX_PINS = 12;
  localparam int TONE_SLOTS = 2;
  localparam int CLK_HZ = 20_000_000;
  localparam int PWM_FMAX_HZ = 1_000_000;
  localparam int TONE_FMAX_HZ = 4_000_000;
  localparam int RST_HOLD_MS = 100;
  // a least period rounds up to whole cycles
  localparam logic [15:0] PWM_MIN_CYC = 16'((CLK_HZ + PWM_FMAX_HZ - 1) / PWM_FMAX_HZ);
  localparam logic [15:0] TONE_MIN_CYC = 16'((CLK_HZ + TONE_FMAX_HZ - 1) / TONE_FMAX_HZ);

  localparam logic [7:0] A_DIR = 8'h00;
  localparam logic [7:0] A_OUT = 8'h04;
  localparam logic [7:0] A_IN = 8'h08;
  localparam logic [7:0] A_DRIVE = 8'h0c;
  localparam logic [7:0] A_PULL_EN = 8'h10;
  localparam logic [7:0] A_PULL_UP = 8'h14;
  localparam logic [7:0] A_PWM_SEL = 8'h18;
  localparam logic [7:0] A_TONE_SEL = 8'h1c;
  localparam logic [7:0] A_PWM_PER = 8'h20;
  localparam logic [7:0] A_PWM_DUTY = 8'h24;
  localparam logic [7:0] A_TONE_PER = 8'h28;
  localparam logic [7:0] A_TONE_DUTY = 8'h2c;
  localparam logic [7:0] A_WAKE_EN = 8'h30;
  localparam logic [7:0] A_WAKE_HI = 8'h34;
  localparam logic [7:0] A_WAKE_CHG = 8'h38;
  localparam logic [7:0] A_INT_STAT = 8'h3c;
  localparam logic [7:0] A_INT_CLR = 8'h40;
  localparam logic [7:0] A_INT_EN = 8'h44;

  localparam int TONE_PIN_W = 5;
  localparam int TONE_EN0_BIT = 5;
  localparam int TONE_PIN1_LSB = 8;
  localparam int TONE_EN1_BIT = 13;
  localparam int TONE_SEL_W = 14;
  localparam int TONE_DUTY1_LSB = 16;

  localparam logic [18:0] RST_PINS = 19'h0;
  localparam logic [15:0] RST_PER = 16'h0;
  localparam logic [13:0] RST_TONE_SEL = 14'h0;

  typedef logic [NPINS-1:0] cpp_pins_t;

  typedef struct packed {
    logic [15:0] period;
    logic [15:0] duty0;
    logic [15:0] duty1;
  } cpp_wave_cfg_s;

  function automatic logic [4:0] cpp_ones(input cpp_pins_t v);
    logic [4:0] n;
    n = 5'h0;
    for (int k = 0; k < NPINS; k++) begin
      n = n + 5'(v[k]);
    end
    return n;
  endfunction : cpp_ones

  // one tone slot: enable bit above a pin index; out-of-range index selects nothing
  function automatic cpp_pins_t cpp_slot_mask(input logic [5:0] slot);
    cpp_pins_t m;
    m = RST_PINS;
    if (slot[TONE_PIN_W] && slot[TONE_PIN_W-1:0] < 5'(NPINS)) begin
      m[slot[TONE_PIN_W-1:0]] = 1'b1;
    end
    return m;
  endfunction : cpp_slot_mask
endpackage : cpp_pkg

// ### rtl/cpp_wave_gen.sv
// period counter with two duty compares, shared by the pulse-width and tone paths
`timescale 1ns/10ps
module cpp_wave_gen
  import cpp_pkg::*;
#(
  parameter logic [15:0] MIN_PER = 16'h0001
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire cpp_wave_cfg_s cfg, // period and two duties in cycles
  output logic [1:0] wave // registered waveforms
);
  logic [15:0] cnt;
  logic [15:0] per_eff;
  logic [15:0] next_cnt;
  logic [1:0] next_wave;
  logic running;

  // periods shorter than the top frequency allows are stretched
  assign per_eff = (cfg.period < MIN_PER) ? MIN_PER : cfg.period;
  // period zero means zero frequency: output parked low
  assign running = (cfg.period != 16'h0);
  assign next_cnt = (!running || cnt >= per_eff - 16'h1) ? 16'h0 : cnt + 16'h1;
  // duty at or above the stretched period gives a steady high
  assign next_wave = running ? {cnt < cfg.duty1, cnt < cfg.duty0} : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0;
      wave <= 2'h0;
    end else begin
      cnt <= next_cnt;
      wave <= next_wave;
    end
  end

  property p_min_period;
    @(posedge pclk) disable iff (!presetn)
    (running && cnt == 16'h0 && $past(cnt) != 16'h0) |-> $past(cnt) >= MIN_PER - 16'h1;
  endproperty
  a_min_period: assert property (p_min_period) else $error("period shorter than minimum");
  property p_zero_off;
    @(posedge pclk) disable iff (!presetn)
    (!running) ##1 (!running) |-> wave == 2'h0;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("wave active at zero frequency");
endmodule : cpp_wave_gen

// ### rtl/cpp_pin_port.sv
// nineteen-pin configurable port with wake detection, pulse-width and tone outputs, apb slave
`timescale 1ns/10ps
module cpp_pin_port
  import cpp_pkg::*;
(
  input wire logic pclk, // bus clock, 20 MHz
  input wire logic presetn, // async reset, active low
  input wire logic [7:0] paddr, // byte address
  input wire logic psel, // slave select
  input wire logic penable, // access phase
  input wire logic pwrite, // 1 = write
  input wire logic [31:0] pwdata, // write data
  output logic [31:0] prdata, // read data
  output logic pready, // transfer done
  output logic pslverr, // unmapped or refused
  input wire cpp_pins_t pin_in, // pin levels, synchronous
  output cpp_pins_t pin_out, // pin output level
  output cpp_pins_t pin_oe_n, // low while driving
  output cpp_pins_t pin_hi_drive, // high drive strength
  output cpp_pins_t pin_pull_up, // pull-up on
  output cpp_pins_t pin_pull_dn, // pull-down on
  output logic irq // enabled wake status pending
);
  cpp_pins_t dir, outv, drive, pull_en, pull_up, pwm_sel;
  cpp_pins_t wake_en, wake_hi, wake_chg, stat, ien, pin_prev;
  logic prev_ok;
  logic [13:0] tone_sel;
  logic [15:0] pwm_per, pwm_duty, tone_per;
  logic [31:0] tone_duty;

  logic acc, wr_go, first;
  logic mapped, pwm_refused;
  logic [31:0] rd_mux;
  cpp_pins_t wdat, clr_mask, hit_lvl, hit_chg, hit, next_stat;
  cpp_pins_t tone_m0, tone_m1, tone_mask, pwm_only, drv;
  logic [15:0] tone_d0, tone_d1, tone_per_eff;
  cpp_wave_cfg_s pwm_cfg, tone_cfg;
  logic [1:0] pwm_w, tone_w;

  assign acc = psel && penable;
  assign first = acc && !pready;
  // writes land on the edge where pready is sampled high
  assign wr_go = acc && pready && pwrite;
  assign wdat = pwdata[NPINS-1:0];

  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= A_INT_EN);
  assign pwm_refused = pwrite && (paddr == A_PWM_SEL) && (cpp_ones(wdat) > 5'(PWM_MAX_PINS));

  assign rd_mux =
    (paddr == A_DIR) ? 32'(dir) :
    (paddr == A_OUT) ? 32'(outv) :
    (paddr == A_IN) ? 32'(pin_in) :
    (paddr == A_DRIVE) ? 32'(drive) :
    (paddr == A_PULL_EN) ? 32'(pull_en) :
    (paddr == A_PULL_UP) ? 32'(pull_up) :
    (paddr == A_PWM_SEL) ? 32'(pwm_sel) :
    (paddr == A_TONE_SEL) ? 32'(tone_sel) :
    (paddr == A_PWM_PER) ? 32'(pwm_per) :
    (paddr == A_PWM_DUTY) ? 32'(pwm_duty) :
    (paddr == A_TONE_PER) ? 32'(tone_per) :
    (paddr == A_TONE_DUTY) ? tone_duty :
    (paddr == A_WAKE_EN) ? 32'(wake_en) :
    (paddr == A_WAKE_HI) ? 32'(wake_hi) :
    (paddr == A_WAKE_CHG) ? 32'(wake_chg) :
    (paddr == A_INT_STAT) ? 32'(stat) :
    (paddr == A_INT_EN) ? 32'(ien) : 32'h0;

  // one wait state, so every bus output comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= first;
      pslverr <= first && (!mapped || pwm_refused);
      prdata <= (first && !pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir <= RST_PINS;
      outv <= RST_PINS;
      drive <= RST_PINS;
      pull_en <= RST_PINS;
      pull_up <= RST_PINS;
    end else if (wr_go) begin
      if (paddr == A_DIR) dir <= wdat;
      if (paddr == A_OUT) outv <= wdat;
      if (paddr == A_DRIVE) drive <= wdat;
      if (paddr == A_PULL_EN) pull_en <= wdat;
      if (paddr == A_PULL_UP) pull_up <= wdat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_sel <= RST_PINS;
      tone_sel <= RST_TONE_SEL;
      pwm_per <= RST_PER;
      pwm_duty <= RST_PER;
      tone_per <= RST_PER;
      tone_duty <= 32'h0;
    end else if (wr_go) begin
      if (paddr == A_PWM_SEL && !pwm_refused) pwm_sel <= wdat;
      if (paddr == A_TONE_SEL) tone_sel <= pwdata[TONE_SEL_W-1:0];
      if (paddr == A_PWM_PER) pwm_per <= pwdata[15:0];
      if (paddr == A_PWM_DUTY) pwm_duty <= pwdata[15:0];
      if (paddr == A_TONE_PER) tone_per <= pwdata[15:0];
      if (paddr == A_TONE_DUTY) tone_duty <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_en <= RST_PINS;
      wake_hi <= RST_PINS;
      wake_chg <= RST_PINS;
      ien <= RST_PINS;
    end else if (wr_go) begin
      if (paddr == A_WAKE_EN) wake_en <= wdat;
      if (paddr == A_WAKE_HI) wake_hi <= wdat;
      if (paddr == A_WAKE_CHG) wake_chg <= wdat;
      if (paddr == A_INT_EN) ien <= wdat;
    end
  end

  assign hit_lvl = wake_en & ~wake_chg & ~(pin_in ^ wake_hi);
  // change triggers; no compare until a previous level exists
  assign hit_chg = wake_en & wake_chg & (pin_in ^ pin_prev) & {NPINS{prev_ok}};
  assign hit = hit_lvl | hit_chg;
  assign clr_mask = (wr_go && paddr == A_INT_CLR) ? wdat : RST_PINS;
  // a new event beats a clear in the same cycle
  assign next_stat = (stat & ~clr_mask) | hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= RST_PINS;
      pin_prev <= RST_PINS;
      prev_ok <= 1'b0;
      irq <= 1'b0;
    end else begin
      stat <= next_stat;
      pin_prev <= pin_in;
      prev_ok <= 1'b1;
      irq <= |(stat & ien);
    end
  end

  // halve the stretched period, else a short request loses its 40 percent (2 of 5 cycles) mark-space
  assign tone_per_eff = (tone_per < TONE_MIN_CYC) ? TONE_MIN_CYC : tone_per;
  // nominal half-period duty when tone duty left at zero
  assign tone_d0 = (tone_duty[15:0] == 16'h0) ? (tone_per_eff >> 1) : tone_duty[15:0];
  assign tone_d1 = (tone_duty[31:16] == 16'h0) ? (tone_per_eff >> 1) : tone_duty[31:16];
  assign pwm_cfg = '{period: pwm_per, duty0: pwm_duty, duty1: 16'h0};
  assign tone_cfg = '{period: tone_per, duty0: tone_d0, duty1: tone_d1};

  cpp_wave_gen #(.MIN_PER(PWM_MIN_CYC)) u_pwm (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(pwm_cfg),
    .wave(pwm_w)
  );

  // tone generator, one counter for both slots
  cpp_wave_gen #(.MIN_PER(TONE_MIN_CYC)) u_tone (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(tone_cfg),
    .wave(tone_w)
  );

  // tone slots; slot 0 wins if both name one pin
  assign tone_m0 = cpp_slot_mask(tone_sel[TONE_EN0_BIT:0]);
  assign tone_m1 = cpp_slot_mask(tone_sel[TONE_EN1_BIT:TONE_PIN1_LSB]) & ~tone_m0;
  assign tone_mask = tone_m0 | tone_m1;
  assign pwm_only = pwm_sel & ~tone_mask;

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      assign drv[gi] = tone_m0[gi] ? tone_w[0] : tone_m1[gi] ? tone_w[1] : pwm_sel[gi] ? pwm_w[0] : outv[gi];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= RST_PINS;
      pin_oe_n <= ~RST_PINS;
      pin_hi_drive <= RST_PINS;
      pin_pull_up <= RST_PINS;
      pin_pull_dn <= RST_PINS;
    end else begin
      pin_out <= drv;
      pin_oe_n <= ~dir;
      pin_hi_drive <= drive & dir;
      pin_pull_up <= pull_en & pull_up;
      pin_pull_dn <= pull_en & ~pull_up;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_dir_write;
    (wr_go && paddr == A_DIR) |-> ##2 pin_oe_n == ~$past(wdat, 2);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write not on pins");
  property p_single_pin;
    (wr_go && paddr == A_OUT) |=> ##1 (pin_out & ~$past(pwm_sel | tone_mask, 2)) ==
      ($past(wdat, 2) & ~$past(pwm_sel | tone_mask, 2));
  endproperty
  a_single_pin: assert property (p_single_pin) else $error("plain pin output wrong");
  property p_pull_excl;
    (pin_pull_up & pin_pull_dn) == RST_PINS;
  endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("pull-up and pull-down together");
  property p_wake_level;
    (hit_lvl != RST_PINS) |=> (stat & $past(hit_lvl)) == $past(hit_lvl);
  endproperty
  a_wake_level: assert property (p_wake_level) else $error("level wake lost");
  property p_wake_change;
    (prev_ok && (wake_en & wake_chg & (pin_in ^ $past(pin_in))) != RST_PINS) |=>
      (stat & $past(hit_chg)) == $past(hit_chg) && $past(hit_chg) != RST_PINS;
  endproperty
  a_wake_change: assert property (p_wake_change) else $error("change wake lost");
  property p_pwm_limit;
    cpp_ones(pwm_sel) <= 5'(PWM_MAX_PINS);
  endproperty
  a_pwm_limit: assert property (p_pwm_limit) else $error("too many pulse-width pins");
  property p_tone_pins;
    cpp_ones(tone_mask) <= 5'(TONE_SLOTS);
  endproperty
  a_tone_pins: assert property (p_tone_pins) else $error("tone on more than two pins");
  property p_pwm_override;
    (pwm_only != RST_PINS) |=> (pin_out & $past(pwm_only)) == ({NPINS{$past(pwm_w[0])}} & $past(pwm_only));
  endproperty
  a_pwm_override: assert property (p_pwm_override) else $error("pulse-width pin not from generator");
  property p_tone_override;
    (tone_m0 != RST_PINS) |=> (pin_out & $past(tone_m0)) == ({NPINS{$past(tone_w[0])}} & $past(tone_m0));
  endproperty
  a_tone_override: assert property (p_tone_override) else $error("tone pin not from generator");
  property p_irq;
    ((stat & ien) != RST_PINS) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  c_wake: cover property (hit != RST_PINS ##1 irq);
  c_pwm_pin: cover property (pwm_only != RST_PINS && pwm_w[0] ##1 !pwm_w[0]);
  c_two_tones: cover property (tone_m0 != RST_PINS && tone_m1 != RST_PINS && tone_w[0] != tone_w[1]);
  c_refused: cover property (pready && pslverr);
endmodule : cpp_pin_port

// ### verification/cpp_host_model.sv
// host-side circuitry that drives and senses the port pins
`timescale 1ns/10ps
module cpp_host_model
  import cpp_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire cpp_pins_t pin_out, // port drive level
  input wire cpp_pins_t pin_oe_n, // low while port drives
  input wire cpp_pins_t pin_pull_up, // pull-up on
  input wire cpp_pins_t pin_pull_dn, // pull-down on
  input wire cpp_pins_t host_en, // host drives the pin
  input wire cpp_pins_t host_val, // host level
  output cpp_pins_t pin_in // resolved pin level
);
  cpp_pins_t float_val = RST_PINS;
  // a floating pin flips each cycle so a stale level never passes
  always @(posedge pclk) begin
    float_val <= ~float_val;
  end
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & host_en & host_val) |
                  (pin_oe_n & ~host_en & (pin_pull_up | (~pin_pull_dn & float_val)));
endmodule : cpp_host_model

// ### verification/configurable_pin_port_pwm_tone_test.sv
// self-checking bench of the pin port over apb
`timescale 1ns/10ps
module configurable_pin_port_pwm_tone_test;
  import cpp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  cpp_pins_t pin_in, pin_out, pin_oe_n, pin_hi_drive, pin_pull_up, pin_pull_dn;
  cpp_pins_t host_en = RST_PINS;
  cpp_pins_t host_val = RST_PINS;
  logic [31:0] rd;
  logic er;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  int i;

  cpp_pin_port cpp_pin_port_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_hi_drive(pin_hi_drive), .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn), .irq(irq));
  cpp_host_model cpp_host_model_inst (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn), .host_en(host_en),
    .host_val(host_val), .pin_in(pin_in));

  always #25 pclk = ~pclk;

  task give_verdict;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // run takes under fifteen hundred cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // request held until pready is seen high at a rising edge
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check("register read", rd, exp);
  endtask : rchk

  task hi_count(input int k, input int n, input logic [31:0] exp);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pin_out[k] === 1'b1) c++;
    end
    check("pin high count", 32'(c), exp);
  endtask : hi_count

  initial begin
    tick(2);
    presetn <= 1'b1;
    tick(1);
    check("oe_n at reset", 32'(pin_oe_n), 32'h7ffff);
    check("pins at reset", 32'(pin_out | pin_hi_drive | pin_pull_up | pin_pull_dn), 32'h0);
    check("irq at reset", 32'(irq), 32'h0);
    for (i = 0; i < 18; i++) begin
      if (i != 2) rchk(8'(i * 4), 32'h0);
    end
    wr(8'h48, 32'hffffffff);
    check("unmapped write error", 32'(er), 32'h1);
    xfer(8'h02, 1'b0, 32'h0);
    check("misaligned read error", 32'(er), 32'h1);
    check("misaligned read data", rd, 32'h0);
    wr(A_DIR, 32'h5a5a5);
    wr(A_OUT, 32'h7ffff);
    wr(A_DRIVE, 32'h7ffff);
    host_en <= 19'h25a5a;
    host_val <= 19'h0f0f0;
    tick(2);
    check("oe_n", 32'(pin_oe_n), 32'h25a5a);
    check("out", 32'(pin_out), 32'h7ffff);
    check("high drive", 32'(pin_hi_drive), 32'h5a5a5);
    rchk(A_IN, 32'(19'h5a5a5 | (19'h25a5a & 19'h0f0f0)));
    wr(A_PULL_EN, 32'h0f0f0);
    wr(A_PULL_UP, 32'h33333);
    tick(2);
    check("pull up", 32'(pin_pull_up), 32'(19'h0f0f0 & 19'h33333));
    check("pull down", 32'(pin_pull_dn), 32'(19'h0f0f0 & ~19'h33333));
    wr(A_DIR, 32'h0);
    host_en <= 19'h7ffff;
    host_val <= 19'h00002;
    wr(A_WAKE_HI, 32'h1);
    wr(A_WAKE_CHG, 32'h4);
    wr(A_WAKE_EN, 32'h7);
    tick(3);
    rchk(A_INT_STAT, 32'h0);
    host_val <= 19'h00003;
    tick(3);
    rchk(A_INT_STAT, 32'h1);
    check("masked irq", 32'(irq), 32'h0);
    wr(A_INT_EN, 32'h7);
    tick(2);
    check("irq", 32'(irq), 32'h1);
    host_val <= 19'h00002;
    wr(A_INT_CLR, 32'h1);
    tick(2);
    rchk(A_INT_STAT, 32'h0);
    check("irq cleared", 32'(irq), 32'h0);
    host_val <= 19'h00000;
    tick(3);
    rchk(A_INT_STAT, 32'h2);
    host_val <= 19'h00002;
    wr(A_INT_CLR, 32'h2);
    host_val <= 19'h00006;
    tick(3);
    rchk(A_INT_STAT, 32'h4);
    wr(A_INT_CLR, 32'h4);
    tick(3);
    rchk(A_INT_STAT, 32'h0);
    host_en <= RST_PINS;
    wr(A_DIR, 32'h7ffff);
    wr(A_PWM_SEL, 32'h01fff);
    check("thirteen pwm pins refused", 32'(er), 32'h1);
    rchk(A_PWM_SEL, 32'h0);
    wr(A_PWM_SEL, 32'h00fff);
    check("twelve pwm pins taken", 32'(er), 32'h0);
    wr(A_PWM_PER, 32'd40);
    wr(A_PWM_DUTY, 32'd10);
    tick(50);
    hi_count(11, 160, 32'd40);
    hi_count(12, 40, 32'd40);
    wr(A_PWM_DUTY, 32'd0);
    tick(50);
    hi_count(0, 80, 32'd0);
    wr(A_PWM_DUTY, 32'd40);
    tick(50);
    hi_count(0, 80, 32'd80);
    // short period is stretched to the 1 MHz limit
    wr(A_PWM_PER, 32'd4);
    wr(A_PWM_DUTY, 32'd10);
    tick(50);
    hi_count(0, 4 * int'(PWM_MIN_CYC), 32'd40);
    wr(A_TONE_SEL, 32'h2423);
    wr(A_TONE_PER, 32'd8);
    wr(A_TONE_DUTY, 32'h00020000);
    tick(20);
    hi_count(3, 80, 32'd40);
    hi_count(4, 80, 32'd20);
    wr(A_TONE_PER, 32'd2);
    tick(20);
    hi_count(4, 16 * int'(TONE_MIN_CYC), 32'd32);
    hi_count(3, 16 * int'(TONE_MIN_CYC), 32'd32);
    wr(A_TONE_PER, 32'd0);
    tick(20);
    hi_count(3, 40, 32'd0);
    wr(A_TONE_SEL, 32'h0003);
    tick(50);
    hi_count(3, 4 * int'(PWM_MIN_CYC), 32'd40);
    give_verdict();
  end
endmodule : configurable_pin_port_pwm_tone_test
